//--- logic/egp_port.sv
// extended and extra general purpose pin block with set/clear registers
// Behaviour
// - ones in 0x300 bits 2:0 clear levels
// - ones in 0x300 bits 5:3 set levels
// - ones in 0x300 bits 8:6 clear enables
// - ones in 0x300 bits 11:9 set enables
// - input levels read at 14:12 and 19:16
// - ones in 0x304 bits 3:0 clear levels
// - ones in 0x304 bits 7:4 set levels
// - ones in 0x304 bits 11:8 clear enables
// - ones in 0x304 bits 15:12 set enables
`timescale 1ns/100ps
`include "egp_map.svh"
module egp_port (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic [11:0] addr_in,
    input wire logic [31:0] wdata_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rdata_out,
    input wire logic [2:0] ext_pin_in,
    output logic [2:0] ext_pin_out,
    output logic [2:0] ext_pin_oen_out,
    output logic [3:0] extra_output_pin_out,
    output logic [3:0] extra_output_pin_oen_out,
    input wire logic [3:0] extra_input_pin_in
);
    egp_pkg::egp_bus_req_t req;
    egp_pkg::egp_ext_state_t ext_st;
    egp_pkg::egp_xio_state_t xio_st;
    logic wr_ext;
    logic wr_xio;
    logic rd_ext;
    logic rd_xio;
    logic [2:0] ext_in_q;
    logic [3:0] xio_in_q;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;

    assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
    // exact match only; neighbouring words stay unmapped
    function automatic logic hit(input logic [`EGP_ADDR_W-1:0] addr, input logic [`EGP_ADDR_W-1:0] ofs);
        return addr == ofs;
    endfunction

    assign wr_ext = req.wr && hit(req.addr, `EGP_OFS_EXT);
    assign wr_xio = req.wr && hit(req.addr, `EGP_OFS_XIO);
    assign rd_ext = req.rd && hit(req.addr, `EGP_OFS_EXT);
    assign rd_xio = req.rd && hit(req.addr, `EGP_OFS_XIO);

    // extended pin levels
    egp_latch_bank #(.WIDTH(`EGP_EXT_N)) u_ext_lvl (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_in(wr_ext),
        .set_in(req.wdata[`EGP_EXT_LVL_SET +: `EGP_EXT_N]),
        .clr_in(req.wdata[`EGP_EXT_LVL_CLR +: `EGP_EXT_N]),
        .q_out(ext_st.lvl)
    );
    // extended pin enables
    egp_latch_bank #(.WIDTH(`EGP_EXT_N)) u_ext_oe (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_in(wr_ext),
        .set_in(req.wdata[`EGP_EXT_OE_SET +: `EGP_EXT_N]),
        .clr_in(req.wdata[`EGP_EXT_OE_CLR +: `EGP_EXT_N]),
        .q_out(ext_st.oe)
    );
    // extra output levels
    egp_latch_bank #(.WIDTH(`EGP_XIO_N)) u_xio_lvl (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_in(wr_xio),
        .set_in(req.wdata[`EGP_XIO_LVL_SET +: `EGP_XIO_N]),
        .clr_in(req.wdata[`EGP_XIO_LVL_CLR +: `EGP_XIO_N]),
        .q_out(xio_st.lvl)
    );
    // extra output enables
    egp_latch_bank #(.WIDTH(`EGP_XIO_N)) u_xio_oe (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .wr_in(wr_xio),
        .set_in(req.wdata[`EGP_XIO_OE_SET +: `EGP_XIO_N]),
        .clr_in(req.wdata[`EGP_XIO_OE_CLR +: `EGP_XIO_N]),
        .q_out(xio_st.oe)
    );

    // pin level sampling
    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            ext_in_q <= `EGP_RST_EXT;
            xio_in_q <= `EGP_RST_XIO;
        end else begin
            ext_in_q <= ext_pin_in;
            xio_in_q <= extra_input_pin_in;
        end
    end

    // read mux; both set and clear fields show the latch
    always_comb begin
        rdata_d = `EGP_RD_ZERO;
        if (rd_ext) begin
            rdata_d[`EGP_EXT_LVL_CLR +: `EGP_EXT_N] = ext_st.lvl;
            rdata_d[`EGP_EXT_LVL_SET +: `EGP_EXT_N] = ext_st.lvl;
            rdata_d[`EGP_EXT_OE_CLR +: `EGP_EXT_N] = ext_st.oe;
            rdata_d[`EGP_EXT_OE_SET +: `EGP_EXT_N] = ext_st.oe;
            rdata_d[`EGP_EXT_IN +: `EGP_EXT_N] = ext_in_q;
        end else if (rd_xio) begin
            rdata_d[`EGP_XIO_LVL_CLR +: `EGP_XIO_N] = xio_st.lvl;
            rdata_d[`EGP_XIO_LVL_SET +: `EGP_XIO_N] = xio_st.lvl;
            rdata_d[`EGP_XIO_OE_CLR +: `EGP_XIO_N] = xio_st.oe;
            rdata_d[`EGP_XIO_OE_SET +: `EGP_XIO_N] = xio_st.oe;
            rdata_d[`EGP_XIO_IN +: `EGP_XIO_N] = xio_in_q;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            rdata_q <= `EGP_RD_ZERO;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign rdata_out = rdata_q;
    assign ext_pin_out = ext_st.lvl;
    assign ext_pin_oen_out = ~ext_st.oe;
    assign extra_output_pin_out = xio_st.lvl;
    assign extra_output_pin_oen_out = ~xio_st.oe;

    AST_EXT_LVL_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[0] && !req.wdata[3] |=> !ext_pin_out[0])
        else $error("extended level not cleared");
    AST_EXT_LVL_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[5] |=> ext_pin_out[2])
        else $error("extended level not set");
    AST_EXT_OE_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[7] && !req.wdata[10] |=> ext_pin_oen_out[1])
        else $error("extended enable not cleared");
    AST_EXT_OE_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[9] |=> !ext_pin_oen_out[0])
        else $error("extended enable not set");
    AST_RD_IN: assert property (@(posedge clk_in) disable iff (!rstn_in)
        req.rd && req.addr == `EGP_OFS_XIO |=> rdata_out[19:16] == $past(xio_in_q) && rdata_out[31:20] == '0)
        else $error("input levels misread");
    AST_XIO_LVL_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[3] && !req.wdata[7] |=> !extra_output_pin_out[3])
        else $error("extra level not cleared");
    AST_XIO_LVL_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[4] |=> extra_output_pin_out[0])
        else $error("extra level not set");
    AST_XIO_OE_CLR: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[8] && !req.wdata[12] |=> extra_output_pin_oen_out[0])
        else $error("extra enable not cleared");
    AST_XIO_OE_SET: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[15] |=> !extra_output_pin_oen_out[3])
        else $error("extra enable not set");
    AST_ZERO_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[15:0] == '0 |=> $stable(extra_output_pin_out) && $stable(extra_output_pin_oen_out))
        else $error("zero write changed state");
    AST_RESV_ZERO: assert property (@(posedge clk_in) disable iff (!rstn_in)
        req.rd && req.addr == `EGP_OFS_EXT |=> rdata_out[31:15] == '0)
        else $error("reserved bits not zero");

    AST_EXT_LVL_CLR1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_LVL_CLR + 1] && !req.wdata[`EGP_EXT_LVL_SET + 1] |=> !ext_pin_out[1])
        else $error("extended level 1 not cleared");

    AST_EXT_LVL_CLR2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_LVL_CLR + 2] && !req.wdata[`EGP_EXT_LVL_SET + 2] |=> !ext_pin_out[2])
        else $error("extended level 2 not cleared");

    AST_EXT_LVL_SET0: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_LVL_SET] |=> ext_pin_out[0])
        else $error("extended level 0 not set");

    AST_EXT_LVL_SET1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_LVL_SET + 1] |=> ext_pin_out[1])
        else $error("extended level 1 not set");

    AST_EXT_OE_CLR0: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_OE_CLR] && !req.wdata[`EGP_EXT_OE_SET] |=> ext_pin_oen_out[0])
        else $error("extended enable 0 not cleared");

    AST_EXT_OE_CLR2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_OE_CLR + 2] && !req.wdata[`EGP_EXT_OE_SET + 2] |=> ext_pin_oen_out[2])
        else $error("extended enable 2 not cleared");

    AST_EXT_OE_SET1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_OE_SET + 1] |=> !ext_pin_oen_out[1])
        else $error("extended enable 1 not set");

    AST_EXT_OE_SET2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_OE_SET + 2] |=> !ext_pin_oen_out[2])
        else $error("extended enable 2 not set");

    AST_XIO_LVL_CLR0: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_LVL_CLR] && !req.wdata[`EGP_XIO_LVL_SET] |=> !extra_output_pin_out[0])
        else $error("extra level 0 not cleared");

    AST_XIO_LVL_CLR1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_LVL_CLR + 1] && !req.wdata[`EGP_XIO_LVL_SET + 1] |=> !extra_output_pin_out[1])
        else $error("extra level 1 not cleared");

    AST_XIO_LVL_CLR2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_LVL_CLR + 2] && !req.wdata[`EGP_XIO_LVL_SET + 2] |=> !extra_output_pin_out[2])
        else $error("extra level 2 not cleared");

    AST_XIO_LVL_SET1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_LVL_SET + 1] |=> extra_output_pin_out[1])
        else $error("extra level 1 not set");

    AST_XIO_LVL_SET2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_LVL_SET + 2] |=> extra_output_pin_out[2])
        else $error("extra level 2 not set");

    AST_XIO_LVL_SET3: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_LVL_SET + 3] |=> extra_output_pin_out[3])
        else $error("extra level 3 not set");

    AST_XIO_OE_CLR1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_CLR + 1] && !req.wdata[`EGP_XIO_OE_SET + 1] |=> extra_output_pin_oen_out[1])
        else $error("extra enable 1 not cleared");

    AST_XIO_OE_CLR2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_CLR + 2] && !req.wdata[`EGP_XIO_OE_SET + 2] |=> extra_output_pin_oen_out[2])
        else $error("extra enable 2 not cleared");

    AST_XIO_OE_CLR3: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_CLR + 3] && !req.wdata[`EGP_XIO_OE_SET + 3] |=> extra_output_pin_oen_out[3])
        else $error("extra enable 3 not cleared");

    AST_XIO_OE_SET0: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_SET] |=> !extra_output_pin_oen_out[0])
        else $error("extra enable 0 not set");

    AST_XIO_OE_SET1: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_SET + 1] |=> !extra_output_pin_oen_out[1])
        else $error("extra enable 1 not set");

    AST_XIO_OE_SET2: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_SET + 2] |=> !extra_output_pin_oen_out[2])
        else $error("extra enable 2 not set");

    AST_EXT_SET_WINS: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_LVL_CLR + 1] && req.wdata[`EGP_EXT_LVL_SET + 1] |=> ext_pin_out[1])
        else $error("extended set did not win");

    AST_XIO_SET_WINS: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_xio && req.wdata[`EGP_XIO_OE_CLR + 1] && req.wdata[`EGP_XIO_OE_SET + 1] |=> !extra_output_pin_oen_out[1])
        else $error("extra set did not win");

    AST_RD_EXT_LVL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_ext |=> rdata_out[`EGP_EXT_LVL_CLR +: `EGP_EXT_N] == $past(ext_pin_out)
            && rdata_out[`EGP_EXT_LVL_SET +: `EGP_EXT_N] == $past(ext_pin_out))
        else $error("extended level fields misread");

    AST_RD_EXT_OE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_ext |=> rdata_out[`EGP_EXT_OE_CLR +: `EGP_EXT_N] == ~$past(ext_pin_oen_out)
            && rdata_out[`EGP_EXT_OE_SET +: `EGP_EXT_N] == ~$past(ext_pin_oen_out))
        else $error("extended enable fields misread");

    AST_RD_EXT_IN: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_ext |=> rdata_out[`EGP_EXT_IN +: `EGP_EXT_N] == $past(ext_in_q))
        else $error("extended input levels misread");

    AST_RD_XIO_LVL: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_xio |=> rdata_out[`EGP_XIO_LVL_CLR +: `EGP_XIO_N] == $past(extra_output_pin_out)
            && rdata_out[`EGP_XIO_LVL_SET +: `EGP_XIO_N] == $past(extra_output_pin_out))
        else $error("extra level fields misread");

    AST_RD_XIO_OE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rd_xio |=> rdata_out[`EGP_XIO_OE_CLR +: `EGP_XIO_N] == ~$past(extra_output_pin_oen_out)
            && rdata_out[`EGP_XIO_OE_SET +: `EGP_XIO_N] == ~$past(extra_output_pin_oen_out))
        else $error("extra enable fields misread");

    AST_RD_IDLE: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !req.rd |=> rdata_out == `EGP_RD_ZERO)
        else $error("read data outside read slot");

    AST_RD_UNMAP: assert property (@(posedge clk_in) disable iff (!rstn_in)
        req.rd && !rd_ext && !rd_xio |=> rdata_out == `EGP_RD_ZERO)
        else $error("unmapped read not zero");

    AST_IN_EXT: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rstn_in |=> ext_in_q == $past(ext_pin_in))
        else $error("extended input not sampled");

    AST_IN_XIO: assert property (@(posedge clk_in) disable iff (!rstn_in)
        rstn_in |=> xio_in_q == $past(extra_input_pin_in))
        else $error("extra input not sampled");

    AST_EXT_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !wr_ext |=> $stable(ext_pin_out) && $stable(ext_pin_oen_out))
        else $error("extended state moved without write");

    AST_XIO_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        !wr_xio |=> $stable(extra_output_pin_out) && $stable(extra_output_pin_oen_out))
        else $error("extra state moved without write");

    AST_EXT_ZERO_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        wr_ext && req.wdata[`EGP_EXT_IN-1:0] == '0 |=> $stable(ext_pin_out) && $stable(ext_pin_oen_out))
        else $error("zero write changed extended state");

    AST_UNMAP_HOLD: assert property (@(posedge clk_in) disable iff (!rstn_in)
        req.wr && !wr_ext && !wr_xio |=> $stable(ext_pin_out) && $stable(extra_output_pin_out))
        else $error("unmapped write changed state");

    AST_RST_EXT: assert property (@(posedge clk_in)
        !rstn_in |=> ext_pin_out == `EGP_RST_EXT && ext_pin_oen_out == ~`EGP_RST_EXT)
        else $error("extended pins not idle after reset");

    AST_RST_XIO: assert property (@(posedge clk_in)
        !rstn_in |=> extra_output_pin_out == `EGP_RST_XIO && extra_output_pin_oen_out == ~`EGP_RST_XIO)
        else $error("extra pins not idle after reset");

    AST_RST_RD: assert property (@(posedge clk_in)
        !rstn_in |=> rdata_out == `EGP_RD_ZERO)
        else $error("read data not zero after reset");

endmodule

//--- include/egp_map.svh
// register offsets, field positions and reset values of the pin block
`ifndef EGP_MAP_SVH
`define EGP_MAP_SVH
`define EGP_ADDR_W 12
`define EGP_OFS_EXT 12'h300
`define EGP_OFS_XIO 12'h304
`define EGP_EXT_N 3
`define EGP_XIO_N 4
`define EGP_EXT_LVL_CLR 0
`define EGP_EXT_LVL_SET 3
`define EGP_EXT_OE_CLR 6
`define EGP_EXT_OE_SET 9
`define EGP_EXT_IN 12
`define EGP_XIO_LVL_CLR 0
`define EGP_XIO_LVL_SET 4
`define EGP_XIO_OE_CLR 8
`define EGP_XIO_OE_SET 12
`define EGP_XIO_IN 16
`define EGP_RST_EXT 3'h0
`define EGP_RST_XIO 4'h0
`define EGP_RD_ZERO 32'h0000_0000
`endif

//--- include/egp_pkg.sv
// types shared by the pin block
package egp_pkg;
    typedef struct packed {
        logic [11:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } egp_bus_req_t;
    typedef struct packed {
        logic [2:0] lvl;
        logic [2:0] oe;
    } egp_ext_state_t;
    typedef struct packed {
        logic [3:0] lvl;
        logic [3:0] oe;
    } egp_xio_state_t;
endpackage

//--- logic/egp_latch_bank.sv
// write-one-set / write-one-clear latch bank
`timescale 1ns/100ps
module egp_latch_bank #(
    parameter int WIDTH = 4
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic wr_in,
    input wire logic [WIDTH-1:0] set_in,
    input wire logic [WIDTH-1:0] clr_in,
    output logic [WIDTH-1:0] q_out
);
    logic [WIDTH-1:0] q_q;
    logic [WIDTH-1:0] q_d;

    // set wins when both set and clear bits are one
    always_comb begin
        q_d = q_q;
        if (wr_in) begin
            q_d = (q_q & ~clr_in) | set_in;
        end
    end

    always_ff @(posedge clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            q_q <= '0;
        end else begin
            q_q <= q_d;
        end
    end

    assign q_out = q_q;
endmodule

//--- bench/egp_board.sv
// board devices on the extended and extra input pins
`timescale 1ns/100ps
module egp_board (
    input wire logic [2:0] lvl_in,
    input wire logic [2:0] oen_in,
    input wire logic [2:0] drv_in,
    input wire logic [3:0] xdrv_in,
    output logic [2:0] ext_wire_out,
    output logic [3:0] xin_out
);
    // a released pin follows the board's own drive
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            ext_wire_out[i] = oen_in[i] ? drv_in[i] : lvl_in[i];
        end
    end
    assign xin_out = xdrv_in;
endmodule

//--- bench/tb_top.sv
// testbench for the pin set/clear register block
`timescale 1ns/100ps
module tb_top;
    logic clk_in = 1'b0;
    logic rstn_in = 1'b0;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic [11:0] addr_in = 12'h000;
    logic [31:0] wdata_in = 32'h0000_0000;
    logic [31:0] rdata_out;
    logic [2:0] ext_pin_in, ext_pin_out, ext_pin_oen_out;
    logic [2:0] drv = 3'h2;
    logic [3:0] xo, xoen, xin;
    logic [3:0] xdrv = 4'h6;
    logic [13:0] pins;
    int bad_count = 0;
    int samples_checked = 0;
    assign pins = {xoen, ext_pin_oen_out, xo, ext_pin_out};
    egp_port egp_port_i (.clk_in(clk_in), .rstn_in(rstn_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .ext_pin_in(ext_pin_in),
        .ext_pin_out(ext_pin_out), .ext_pin_oen_out(ext_pin_oen_out), .extra_output_pin_out(xo),
        .extra_output_pin_oen_out(xoen), .extra_input_pin_in(xin));
    egp_board egp_board_i (.lvl_in(ext_pin_out), .oen_in(ext_pin_oen_out), .drv_in(drv),
        .xdrv_in(xdrv), .ext_wire_out(ext_pin_in), .xin_out(xin));
    initial begin
        forever #10 clk_in = ~clk_in;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            bad_count++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] v);
        @(posedge clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge clk_in);
        wr_in <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [11:0] a, input logic [31:0] exp);
        @(posedge clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clk_in);
        rd_in <= 1'b0;
        #1;
        chk(rdata_out, exp);
    endtask
    task automatic t_reset();
        chk(32'(pins), 32'h0000_3F80);
        rd(12'h300, 32'h0000_2000);
        rd(12'h304, 32'h0006_0000);
    endtask
    task automatic t_ext();
        wr(12'h300, 32'h0000_0E38);
        chk(32'(pins), 32'h0000_3C07);
        rd(12'h300, 32'h0000_7FFF);
        wr(12'h300, 32'h0000_0002);
        chk(32'(pins), 32'h0000_3C05);
        wr(12'h300, 32'h0000_00C0);
        chk(32'(pins), 32'h0000_3D85);
        rd(12'h300, 32'h0000_692D);
        wr(12'h300, 32'h0000_0012);
        chk(32'(pins), 32'h0000_3D87);
    endtask
    task automatic t_xio();
        wr(12'h304, 32'h0000_F0F0);
        chk(32'(pins), 32'h0000_01FF);
        wr(12'h304, 32'h0000_0305);
        chk(32'(pins), 32'h0000_0DD7);
        rd(12'h304, 32'h0006_CCAA);
        @(posedge clk_in);
        drv <= 3'h5;
        xdrv <= 4'h9;
        rd(12'h304, 32'h0009_CCAA);
        rd(12'h300, 32'h0000_593F);
        @(posedge clk_in);
        drv <= 3'h2;
        xdrv <= 4'h6;
    endtask
    task automatic t_unmapped();
        wr(12'h308, 32'hFFFF_FFFF);
        chk(32'(pins), 32'h0000_0DD7);
        rd(12'h308, 32'h0000_0000);
    endtask
    task automatic summarize();
        if (bad_count == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    initial begin
        #20000;
        bad_count++;
        summarize();
    end
    initial begin
        repeat (8) @(posedge clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_ext();
        t_xio();
        t_unmapped();
        @(posedge clk_in);
        rstn_in <= 1'b0;
        @(posedge clk_in);
        rstn_in <= 1'b1;
        #1;
        t_reset();
        summarize();
    end
endmodule
